/* File: hw/cwr_rotator.sv */
// Functional notes
// RULE_01 - six 32-bit read/write pattern registers, two pairs
// RULE_02 - async bit lasts one or two CPU cycles
// RULE_03 - synchronous memories: one bit per CPU cycle
// RULE_04 - second register set uses pair 2/3 settings
// RULE_05 - software keeps pair 0/1 word0 reset value
// RULE_06 - bit 0 leaves with row strobe assertion
// RULE_07 - bit one deasserts, zero asserts column strobe
// RULE_08 - row strobe released after final pulse ends
// RULE_09 - pattern rotates across all 96 bits
// RULE_10 - full rate: four low ones, two-clock levels
// RULE_11 - halved rate: two low ones, one-bit levels
// RULE_12 - sync strobe at first fall, bit0 delayed
// RULE_13 - software programs 2N-1 leading ones
// RULE_14 - SDRAM holds strobe, ROM only first column
// RULE_15 - software programs one rise per beat
// RULE_16 - first rise one or two bits after fall
// RULE_17 - two-zero extra delay only at full clock
// RULE_18 - software fills remaining bits with 01
// RULE_19 - divided clock ignores odd rises
// RULE_20 - shared registers need equal RAS-to-CAS delay
// RULE_21 - shared async DRAM uses halved clock
// RULE_22 - five ones then alternating gives 6/2/2
// RULE_23 - bit index restarts at zero per access
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`default_nettype none
module cwr_rotator #(
  parameter logic [31:0] PAT01_W0_RESET = cwr_pkg::PAT01_W0_RST
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mem_clk,
  input wire cwr_pkg::cwr_acc_t acc,
  output var cwr_pkg::cwr_mem_t mem,
  output logic busy,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cwr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [cwr_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import cwr_pkg::*;

  typedef struct packed {
    logic [PAT_WORDS-1:0][31:0] pat;
    logic [CFG_W-1:0] cfg;
    cwr_state_t st;
    logic [PAT_BITS-1:0] wave;
    logic [6:0] idx;
    logic div;
    logic per2;
    cwr_kind_t kind;
    logic pair;
    logic [3:0] beats;
    logic [3:0] cnt;
    logic [3:0] rises;
    logic prev;
    logic cas_seen;
    logic [1:0] zrun;
    logic twozero;
    logic div2;
    cwr_mem_t mem;
    logic busy;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cwr_core_t;

  cwr_core_t core_reg;
  cwr_core_t core_next;
  logic mclk_rise;

  // ------------------------------------------------------------
  // memory clock edge finder
  // ------------------------------------------------------------
  cwr_edge_sync u_mem_clk_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(mem_clk),
    .rise(mclk_rise)
  );

  // byte-lane merge for a register write
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // word index of a pattern register, or PAT_WORDS when not one
  function automatic logic [2:0] pat_slot(input logic [ADDR_W-1:0] a);
    logic [2:0] slot;
    slot = 3'(PAT_WORDS);
    if (a[1:0] == 2'b00 && a < OFF_CFG) begin
      slot = a[4:2];
    end
    return slot;
  endfunction

  logic halved_req;
  logic div2_req;
  logic [PAT_BITS-1:0] wave_req;
  logic [6:0] nidx;
  logic cur_bit;
  logic nxt_bit;
  logic fall_now;
  logic rise_now;
  logic ref_hit;

  // ------------------------------------------------------------
  // settings picked for the requested pair and memory kind
  // ------------------------------------------------------------
  always_comb begin
    halved_req = acc.pair ? (core_reg.cfg[CFG_HALVE23] | core_reg.cfg[CFG_HW23]) // RULE_04
                          : (core_reg.cfg[CFG_HALVE01] | core_reg.cfg[CFG_HW01]); // RULE_02
    // ROM runs on divided clock 0; SDRAM on the clock of its pair
    if (acc.kind == KIND_SYNC_MASK_ROM) begin
      div2_req = core_reg.cfg[CFG_SD0_DIV2];
    end else begin
      div2_req = acc.pair ? core_reg.cfg[CFG_SD2_DIV2] : core_reg.cfg[CFG_SD1_DIV2];
    end
    wave_req = acc.pair ? {core_reg.pat[5], core_reg.pat[4], core_reg.pat[3]} // RULE_04
                        : {core_reg.pat[2], core_reg.pat[1], core_reg.pat[0]};
  end

  // ------------------------------------------------------------
  // pattern walk terms
  // ------------------------------------------------------------
  always_comb begin
    nidx = (core_reg.idx == IDX_LAST) ? 7'h00 : core_reg.idx + 7'h01; // RULE_09
    cur_bit = core_reg.wave[core_reg.idx];
    nxt_bit = core_reg.wave[nidx];
    fall_now = core_reg.prev & ~cur_bit & ~core_reg.cas_seen;
    rise_now = core_reg.cas_seen & ~core_reg.prev & cur_bit;
    // divided clock with two initial zeros: take the reference a bit early so the
    // extra half-cycle vanishes; otherwise odd rises are skipped when divided
    if (core_reg.div2 && core_reg.twozero) begin
      ref_hit = ~cur_bit & nxt_bit & core_reg.rises[0]; // RULE_17
    end else begin
      ref_hit = rise_now & (~core_reg.div2 | core_reg.rises[0]); // RULE_19
    end
  end

  // ------------------------------------------------------------
  // next state: bus slave and strobe sequencer
  // ------------------------------------------------------------
  always_comb begin
    core_next = core_reg;
    core_next.mem.latch_ref = 1'b0;

    // write address and data are taken in either order
    if (s_axi_awvalid && core_reg.awready) begin
      core_next.awaddr = s_axi_awaddr;
      core_next.aw_got = 1'b1;
      core_next.awready = 1'b0;
    end
    if (s_axi_wvalid && core_reg.wready) begin
      core_next.wdata = s_axi_wdata;
      core_next.wstrb = s_axi_wstrb;
      core_next.w_got = 1'b1;
      core_next.wready = 1'b0;
    end
    if (core_reg.aw_got && core_reg.w_got && !core_reg.bvalid) begin
      core_next.aw_got = 1'b0;
      core_next.w_got = 1'b0;
      core_next.bvalid = 1'b1;
      core_next.bresp = RESP_OKAY;
      if (pat_slot(core_reg.awaddr) < 3'(PAT_WORDS)) begin
        core_next.pat[pat_slot(core_reg.awaddr)] =
          merge_bytes(core_reg.pat[pat_slot(core_reg.awaddr)], core_reg.wdata, core_reg.wstrb); // RULE_01
      end else if (core_reg.awaddr == OFF_CFG) begin
        core_next.cfg = CFG_W'(merge_bytes(32'(core_reg.cfg), core_reg.wdata, core_reg.wstrb));
      end else if (core_reg.awaddr != OFF_STAT) begin
        core_next.bresp = RESP_SLVERR;
      end
    end
    if (core_reg.bvalid && s_axi_bready) begin
      core_next.bvalid = 1'b0;
      core_next.awready = 1'b1;
      core_next.wready = 1'b1;
    end

    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && core_reg.arready) begin
      core_next.arready = 1'b0;
      core_next.rvalid = 1'b1;
      core_next.rresp = RESP_OKAY;
      core_next.rdata = 32'h0000_0000;
      if (pat_slot(s_axi_araddr) < 3'(PAT_WORDS)) begin
        core_next.rdata = core_reg.pat[pat_slot(s_axi_araddr)]; // RULE_01
      end else if (s_axi_araddr == OFF_CFG) begin
        core_next.rdata = 32'(core_reg.cfg);
      end else if (s_axi_araddr == OFF_STAT) begin
        core_next.rdata[STAT_IDX_LSB +: 7] = core_reg.idx;
        core_next.rdata[STAT_BUSY] = core_reg.busy;
        core_next.rdata[STAT_CNT_LSB +: 4] = core_reg.cnt;
        core_next.rdata[STAT_PAIR] = core_reg.pair;
        core_next.rdata[STAT_KIND_LSB +: 2] = core_reg.kind;
      end else begin
        core_next.rresp = RESP_SLVERR;
      end
    end
    if (core_reg.rvalid && s_axi_rready) begin
      core_next.rvalid = 1'b0;
      core_next.arready = 1'b1;
    end

    unique case (core_reg.st)
      ST_IDLE: begin
        if (acc.start) begin
          // the pattern is frozen for the access so a write mid-burst cannot tear it
          core_next.wave = wave_req;
          core_next.idx = 7'h00; // RULE_23
          core_next.div = 1'b0;
          core_next.cnt = 4'h0;
          core_next.rises = 4'h0;
          core_next.zrun = 2'b00;
          core_next.twozero = 1'b0;
          core_next.cas_seen = 1'b0;
          core_next.prev = 1'b1;
          core_next.kind = acc.kind;
          core_next.pair = acc.pair;
          core_next.beats = (acc.beats == 4'h0) ? 4'h1 : acc.beats;
          core_next.div2 = div2_req;
          core_next.busy = 1'b1;
          if (acc.kind == KIND_ADRAM) begin
            core_next.per2 = halved_req; // RULE_02
            // halved bits must line up with the memory clock rising edge
            if (halved_req) begin
              core_next.st = ST_WAIT_EDGE;
            end else begin
              core_next.st = ST_RUN;
              core_next.mem.row_strobe_n = 1'b0; // RULE_06
              core_next.mem.col_strobe_n = wave_req[0];
              core_next.mem.byte_mask_n = wave_req[0];
            end
          end else begin
            core_next.per2 = 1'b0; // RULE_03
            core_next.st = ST_SRUN;
            core_next.mem.sdram_select_n = 1'b0;
          end
        end
      end
      ST_WAIT_EDGE: begin
        if (mclk_rise) begin
          core_next.st = ST_RUN;
          core_next.mem.row_strobe_n = 1'b0; // RULE_06
          core_next.mem.col_strobe_n = core_reg.wave[0];
          core_next.mem.byte_mask_n = core_reg.wave[0];
        end
      end
      ST_RUN: begin
        core_next.div = core_reg.per2 & ~core_reg.div; // RULE_02
        if (!core_reg.per2 || core_reg.div) begin
          core_next.idx = nidx; // RULE_09
          core_next.mem.col_strobe_n = nxt_bit; // RULE_07
          core_next.mem.byte_mask_n = nxt_bit;
          // a pulse ends when the strobe goes from asserted to released
          if (!core_reg.mem.col_strobe_n && nxt_bit) begin
            core_next.cnt = core_reg.cnt + 4'h1;
            if (core_reg.cnt + 4'h1 == core_reg.beats) begin
              core_next.st = ST_DONE; // RULE_08
            end
          end
        end
      end
      ST_SRUN: begin
        core_next.idx = nidx; // RULE_03
        core_next.prev = cur_bit;
        if (fall_now) begin
          core_next.cas_seen = 1'b1;
          core_next.mem.sync_col_strobe_n = 1'b0; // RULE_12
        end else if (core_reg.kind == KIND_SYNC_MASK_ROM) begin
          core_next.mem.sync_col_strobe_n = 1'b1; // RULE_14
        end
        if ((fall_now || core_reg.cas_seen) && !cur_bit && core_reg.rises == 4'h0 && core_reg.zrun != 2'b11) begin
          core_next.zrun = core_reg.zrun + 2'b01;
        end
        if (rise_now) begin
          core_next.rises = core_reg.rises + 4'h1;
          if (core_reg.rises == 4'h0 && core_reg.zrun == 2'b10) begin
            core_next.twozero = 1'b1; // RULE_17
          end
        end
        if (ref_hit) begin
          core_next.mem.latch_ref = 1'b1; // RULE_22
          core_next.cnt = core_reg.cnt + 4'h1;
          if (core_reg.cnt + 4'h1 == core_reg.beats) begin
            core_next.st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // the releasing edge comes one cycle after the last pulse ended
        core_next.mem.row_strobe_n = 1'b1; // RULE_08
        core_next.mem.col_strobe_n = 1'b1;
        core_next.mem.byte_mask_n = 1'b1;
        core_next.mem.sdram_select_n = 1'b1;
        core_next.mem.sync_col_strobe_n = 1'b1; // RULE_14
        core_next.busy = 1'b0;
        core_next.st = ST_IDLE;
      end
      default: begin
        core_next.st = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      core_reg <= '0;
      core_reg.pat[0] <= PAT01_W0_RESET; // RULE_05
      core_reg.pat[1] <= PAT_RST;
      core_reg.cfg <= CFG_RST;
      core_reg.st <= ST_IDLE;
      core_reg.prev <= 1'b1;
      core_reg.mem <= '{row_strobe_n: 1'b1, col_strobe_n: 1'b1, byte_mask_n: 1'b1,
                        sdram_select_n: 1'b1, sync_col_strobe_n: 1'b1, latch_ref: 1'b0};
      core_reg.awready <= 1'b1;
      core_reg.wready <= 1'b1;
      core_reg.arready <= 1'b1;
    end else begin
      core_reg <= core_next;
    end
  end

  // outputs straight from the state register
  assign mem = core_reg.mem;
  assign busy = core_reg.busy;
  assign s_axi_awready = core_reg.awready;
  assign s_axi_wready = core_reg.wready;
  assign s_axi_bvalid = core_reg.bvalid;
  assign s_axi_bresp = core_reg.bresp;
  assign s_axi_arready = core_reg.arready;
  assign s_axi_rvalid = core_reg.rvalid;
  assign s_axi_rdata = core_reg.rdata;
  assign s_axi_rresp = core_reg.rresp;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_pat_write: assert property ((core_reg.aw_got && core_reg.w_got && !core_reg.bvalid && // RULE_01
      core_reg.awaddr == OFF_PAT01_W1 && core_reg.wstrb == 4'hF) |=> core_reg.pat[1] == $past(core_reg.wdata))
    else $error("pattern word write lost");
  a_row_bit0: assert property ($fell(mem.row_strobe_n) |-> mem.col_strobe_n == core_reg.wave[0]) // RULE_06
    else $error("bit 0 not out with row strobe");
  a_col_follow: assert property ((core_reg.st == ST_RUN && $past(core_reg.st) == ST_RUN) // RULE_07
      |-> mem.col_strobe_n == core_reg.wave[core_reg.idx] && mem.byte_mask_n == mem.col_strobe_n)
    else $error("column strobe not following pattern bit");
  a_bit_halved: assert property ((core_reg.st == ST_RUN && core_reg.per2 && !core_reg.div) // RULE_02
      |=> core_reg.idx == $past(core_reg.idx) ##1 (core_reg.idx != $past(core_reg.idx) || core_reg.st == ST_DONE))
    else $error("halved bit not two cycles long");
  a_sync_step: assert property ((core_reg.st == ST_SRUN) |=> core_reg.idx == $past(nidx)) // RULE_03
    else $error("synchronous bit not one cycle");
  a_row_release: assert property ((core_reg.kind == KIND_ADRAM && $rose(mem.col_strobe_n) // RULE_08
      && !mem.row_strobe_n && core_reg.cnt == core_reg.beats) |=> mem.row_strobe_n && !busy)
    else $error("row strobe not released after last pulse");
  a_rotate_wrap: assert property ((core_reg.st == ST_RUN && core_reg.idx == IDX_LAST && // RULE_09
      (!core_reg.per2 || core_reg.div)) |=> core_reg.idx == 7'h00)
    else $error("pattern did not rotate to bit 0");
  a_sync_fall: assert property ($fell(mem.sync_col_strobe_n) |-> !mem.sdram_select_n && // RULE_12
      $past(core_reg.prev) && !$past(cur_bit))
    else $error("sync strobe not at first falling bit");
  a_sdram_hold: assert property ((core_reg.kind == KIND_SDRAM && core_reg.st == ST_SRUN && // RULE_14
      !mem.sync_col_strobe_n) |=> !mem.sync_col_strobe_n)
    else $error("sdram column strobe dropped mid-burst");
  a_rom_single: assert property ((core_reg.kind == KIND_SYNC_MASK_ROM && $fell(mem.sync_col_strobe_n)) // RULE_14
      |=> mem.sync_col_strobe_n)
    else $error("rom column strobe held past first column");
  a_odd_skip: assert property ((core_reg.st == ST_SRUN && core_reg.div2 && !core_reg.twozero && // RULE_19
      rise_now && !core_reg.rises[0]) |=> !mem.latch_ref)
    else $error("odd rise used as reference");
  a_start_idx: assert property ((core_reg.st == ST_IDLE && acc.start) |=> core_reg.idx == 7'h00 && busy) // RULE_23
    else $error("bit index not restarted");

endmodule
`default_nettype wire

/* File: hw/cwr_pkg.sv */
`default_nettype none
package cwr_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses on the register bus)
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_PAT01_W0 = 8'h00;
  localparam logic [7:0] OFF_PAT01_W1 = 8'h04;
  localparam logic [7:0] OFF_PAT01_W2 = 8'h08;
  localparam logic [7:0] OFF_PAT23_W0 = 8'h0C;
  localparam logic [7:0] OFF_PAT23_W1 = 8'h10;
  localparam logic [7:0] OFF_PAT23_W2 = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam int PAT_WORDS = 6;

  // ------------------------------------------------------------
  // configuration register fields and reset values
  // ------------------------------------------------------------
  localparam int CFG_HALVE01 = 0;
  localparam int CFG_HALVE23 = 1;
  localparam int CFG_HW01 = 2;
  localparam int CFG_HW23 = 3;
  localparam int CFG_SD0_DIV2 = 4;
  localparam int CFG_SD1_DIV2 = 5;
  localparam int CFG_SD2_DIV2 = 6;
  localparam int CFG_W = 7;
  localparam logic [6:0] CFG_RST = 7'h00;
  localparam logic [31:0] PAT01_W0_RST = 32'hAAAA_AAA7;
  localparam logic [31:0] PAT_RST = 32'h0000_0000;

  // status register field positions
  localparam int STAT_IDX_LSB = 0;
  localparam int STAT_BUSY = 7;
  localparam int STAT_CNT_LSB = 8;
  localparam int STAT_PAIR = 12;
  localparam int STAT_KIND_LSB = 13;

  // ------------------------------------------------------------
  // pattern walk and bus answers
  // ------------------------------------------------------------
  localparam int PAT_BITS = 96;
  localparam logic [6:0] IDX_LAST = 7'h5F;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    KIND_ADRAM = 2'b00,
    KIND_SDRAM = 2'b01,
    KIND_SYNC_MASK_ROM = 2'b10
  } cwr_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_EDGE = 3'b001,
    ST_RUN = 3'b010,
    ST_SRUN = 3'b011,
    ST_DONE = 3'b100
  } cwr_state_t;

  // access request from the bank sequencer
  typedef struct packed {
    logic start;
    logic pair;
    cwr_kind_t kind;
    logic [3:0] beats;
  } cwr_acc_t;

  // memory-side strobes
  typedef struct packed {
    logic row_strobe_n;
    logic col_strobe_n;
    logic byte_mask_n;
    logic sdram_select_n;
    logic sync_col_strobe_n;
    logic latch_ref;
  } cwr_mem_t;

endpackage
`default_nettype wire

/* File: hw/cwr_edge_sync.sv */
`default_nettype none
module cwr_edge_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } cwr_sync_t;

  cwr_sync_t sync_reg;
  cwr_sync_t sync_next;

  // ------------------------------------------------------------
  // two-stage synchroniser, edge found past the second stage only
  // ------------------------------------------------------------
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = async_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    sync_next.rise = sync_reg.s2 & ~sync_reg.s3;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign rise = sync_reg.rise;

endmodule
`default_nettype wire

/* File: verif/cwr_mem_model.sv */
`default_nettype none
// ----------------------------------------
// far-side memory: counts what its pins see
// ----------------------------------------
module cwr_mem_model (
  input wire logic mclk,
  input wire cwr_pkg::cwr_mem_t mem,
  output logic [7:0] col_pulses,
  output logic [7:0] refs
);
  timeunit 1ns;
  timeprecision 1ns;
  import cwr_pkg::*;
  logic act_reg;
  logic col_reg;
  // counts restart only when an access opens, so the bench can read them after it ends
  always @(posedge mclk) begin
    act_reg <= !(mem.row_strobe_n && mem.sdram_select_n);
    col_reg <= mem.col_strobe_n;
    if (!act_reg && !(mem.row_strobe_n && mem.sdram_select_n)) begin
      col_pulses <= 8'h00;
      refs <= 8'h00;
    end else begin
      if (col_reg && !mem.col_strobe_n) col_pulses <= col_pulses + 8'h01;
      if (mem.latch_ref) refs <= refs + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: verif/cwr_rotator_tb.sv */
`default_nettype none
module cwr_rotator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cwr_pkg::*;
  logic mclk, rst_n, mem_clk, awv, wv, bry, arv, rry, busy, awr, wrd, bv, arr, rv;
  logic [7:0] awa, ara, npul, nref;
  logic [31:0] wd, rdt;
  logic [3:0] ws;
  logic [1:0] br, rr;
  cwr_acc_t acc;
  cwr_mem_t mem;
  cwr_mem_t tr [0:47];
  logic bz [0:47];
  int num_errors, cmp_count;

  cwr_rotator i_cwr_rotator (.mclk(mclk), .rst_n(rst_n), .mem_clk(mem_clk), .acc(acc), .mem(mem), .busy(busy),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rdt), .s_axi_rresp(rr));
  cwr_mem_model i_cwr_mem_model (.mclk(mclk), .mem(mem), .col_pulses(npul), .refs(nref));

  // --------------------------------
  // clocks; memory clock has its own phase
  // --------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    mem_clk = 1'b0;
    #17;
    forever #40 mem_clk = ~mem_clk;
  end

  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    wrap_up();
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    ws <= s;
    bry <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv && bry) begin
        chk(br, er, "bresp");
        bry <= 1'b0;
      end
      if (n > 50) hang();
    end while (awv || wv || bry);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arv && arr) arv <= 1'b0;
      if (rv && rry) begin
        chk(rr, er, "rresp");
        if (er === RESP_OKAY) chk(rdt, exp, "rdata");
        rry <= 1'b0;
      end
      if (n > 50) hang();
    end while (arv || rry);
  endtask
  // start one access and record n cycles of strobes; rf retries start while busy
  task automatic go(input logic p, input logic [1:0] k, input logic [3:0] b, input logic rf, input int n);
    @(posedge mclk);
    acc <= '{1'b1, p, cwr_kind_t'(k), b};
    @(posedge mclk);
    acc.start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      #1;
      tr[i] = mem;
      bz[i] = busy;
      @(posedge mclk);
      acc.start <= rf && (i == 1);
    end
  endtask
  task automatic sync_run(input logic [1:0] kd, input logic [3:0] b, input int r0, input int st, input int f);
    int e;
    go(1'b0, kd, b, 1'b0, 20);
    e = r0 + st * (int'(b) - 1) + 1;
    for (int i = 0; i < 20; i++) begin
      chk(tr[i].sdram_select_n, i >= e, "select");
      chk(tr[i].sync_col_strobe_n, !(i >= f && ((kd == 2'b10) ? (i == f) : (i < e))), "scas");
      chk(tr[i].latch_ref, i < e && i >= r0 && (i - r0) % st == 0, "ref");
      chk(bz[i], i < e, "busy");
    end
    chk(nref, b, "refs");
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs;
    rd(OFF_PAT01_W0, PAT01_W0_RST, RESP_OKAY);
    rd(OFF_PAT23_W2, PAT_RST, RESP_OKAY);
    wr(OFF_PAT01_W1, 32'h1122_3344, 4'h5, RESP_OKAY);
    rd(OFF_PAT01_W1, 32'h0022_0044, RESP_OKAY);
    wr(8'h20, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    rd(8'h20, 32'h0000_0000, RESP_SLVERR);
    wr(OFF_STAT, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_0000, RESP_OKAY);
    $display("test regs done");
  endtask
  task automatic t_async_full;
    wr(OFF_PAT01_W0, 32'hFFFF_FF0F, 4'hF, RESP_OKAY);
    go(1'b0, 2'b00, 4'h1, 1'b1, 12);
    for (int k = 0; k < 10; k++) begin
      chk(tr[k].row_strobe_n, k == 9, "row");
      chk(tr[k].col_strobe_n, k < 4 || k >= 8, "col");
      chk(tr[k].byte_mask_n, k < 4 || k >= 8, "mask");
    end
    chk(bz[8], 1'b1, "busy");
    chk(bz[11], 1'b0, "retry ignored");
    chk(npul, 1, "pulses");
    wr(OFF_PAT01_W1, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    wr(OFF_PAT01_W2, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    // two pulses, one programmed: the second only comes once the walk wraps past bit 95
    go(1'b0, 2'b00, 4'h2, 1'b0, 48);
    chk(tr[47].row_strobe_n, 1'b0, "row held");
    for (int k = 0; k < 100 && busy !== 1'b0; k++) @(posedge mclk);
    if (busy !== 1'b0) hang();
    chk(npul, 2, "pulses rotated");
    $display("test async full done");
  endtask
  // halving and half width both stretch bits on pair 2/3
  task automatic t_async_half;
    int s;
    wr(OFF_PAT23_W0, 32'hFFFF_FFF3, 4'hF, RESP_OKAY);
    for (int c = 0; c < 2; c++) begin
      wr(OFF_CFG, (c == 0) ? 32'h0000_0002 : 32'h0000_0008, 4'hF, RESP_OKAY);
      go(1'b1, 2'b00, 4'h1, 1'b0, 40);
      s = 0;
      while (s < 28 && tr[s].row_strobe_n !== 1'b0) s++;
      if (s == 28) hang();
      for (int j = 0; j < 10; j++) chk(tr[s + j].col_strobe_n, j < 4 || j >= 8, "col2");
      chk(tr[s + 8].row_strobe_n, 1'b0, "row2");
      chk(tr[s + 9].row_strobe_n, 1'b1, "row2");
    end
    $display("test async halved done");
  endtask
  task automatic t_sync;
    wr(OFF_PAT01_W0, 32'h5555_555F, 4'hF, RESP_OKAY);
    wr(OFF_PAT01_W1, 32'h5555_5555, 4'hF, RESP_OKAY);
    wr(OFF_PAT01_W2, 32'h5555_5555, 4'hF, RESP_OKAY);
    wr(OFF_CFG, 32'h0000_0000, 4'hF, RESP_OKAY);
    sync_run(2'b01, 4'h2, 7, 2, 6);
    sync_run(2'b10, 4'h1, 7, 2, 6);
    wr(OFF_CFG, 32'h0000_0030, 4'hF, RESP_OKAY);
    sync_run(2'b01, 4'h2, 9, 4, 6);
    sync_run(2'b10, 4'h1, 9, 4, 6);
    // boot pattern: three ones, two zeros; the extra latch cycle only counts at full clock
    wr(OFF_PAT01_W0, PAT01_W0_RST, 4'hF, RESP_OKAY);
    sync_run(2'b10, 4'h1, 7, 4, 4);
    wr(OFF_CFG, 32'h0000_0000, 4'hF, RESP_OKAY);
    sync_run(2'b10, 4'h1, 6, 2, 4);
    $display("test sync done");
  endtask

  initial begin
    rst_n = 1'b0;
    acc = '0;
    {awv, wv, bry, arv, rry} = 5'h00;
    {awa, ara, wd, ws} = '0;
    num_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_async_full();
    t_async_half();
    t_sync();
    wrap_up();
  end
endmodule
`default_nettype wire
